// file: dv/dsg_engine_test.sv
// dsg_engine_test: self-checking bench for the scatter-gather engine.
// assumes dsg_pkg, dsg_engine and dsg_mem_model are compiled first.
`default_nettype none
module dsg_engine_test
  import dsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, req_burst = 32'h0;
  logic [3:0] lat = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_req, mem_we, mem_ack;
  logic [1:0] s_bresp, s_rresp, mem_size;
  logic [31:0] s_rdata, mem_addr, mem_wdata, mem_rdata, chan_done;
  int n_errors = 0, cmp_count = 0;
  int done_cnt [0:2] = '{0, 0, 0};
  dsg_engine i_dut (
    .aclk, .aresetn, .clken(1'b1), .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hF),
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .req_single(32'h0), .req_burst, .mem_req, .mem_we,
    .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .chan_done
  );
  dsg_mem_model i_mem (.aclk, .lat, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata);
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) for (int i = 0; i < 3; i++) if (chan_done[i] === 1'b1) done_cnt[i]++;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      n++;
    end while (s_bvalid !== 1'b1 && n < 100);
    s_bready <= 1'b0;
    check("write resp", {29'h0, s_bvalid, s_bresp}, {29'h0, 1'b1, resp});
    if (n == 100) close_out();
    // one idle edge so the next call never re-raises bready in the same step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
      n++;
    end while (s_rvalid !== 1'b1 && n < 100);
    s_rready <= 1'b0;
    check("read resp", {29'h0, s_rvalid, s_rresp}, {29'h0, 1'b1, resp});
    check("read data", s_rdata, exp);
    if (n == 100) close_out();
    @(posedge aclk);
  endtask
  function automatic logic [31:0] m(input int a);
    return i_mem.mem[a >> 2];
  endfunction
  // arbitration of four items lets each primary block copy one whole entry
  function automatic logic [31:0] cw(input logic [1:0] di, input logic [1:0] sz, input logic [1:0] si,
    input int n, input logic [2:0] mode);
    return {di, sz, si, sz, 6'h0, 4'h2, 10'(n - 1), 1'b0, mode};
  endfunction
  task automatic entry(input int a, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
    i_mem.mem[a >> 2] = s;
    i_mem.mem[(a >> 2) + 1] = d;
    i_mem.mem[(a >> 2) + 2] = c;
  endtask
  task automatic wait_done(input int ch);
    for (int n = 0; n < 3000 && done_cnt[ch] == 0; n++) @(posedge aclk);
    check("completion seen", 32'(done_cnt[ch] > 0), 32'h1);
    if (done_cnt[ch] == 0) close_out();
    repeat (20) @(posedge aclk);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_regs();
    rd(REG_ENASET, 32'h0, RESP_OKAY);
    rd(REQUEST_MASK_SET_REG, 32'h0, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, RESP_SLVERR);
    wr(REG_CFG, 32'h1, RESP_OKAY);
    rd(REG_CFG, 32'h1, RESP_OKAY);
    wr(REG_CTLBASE, 32'h0, RESP_OKAY);
  endtask
  task automatic test_mem_sg();
    entry(32'h000, 32'h81C, 32'h20C, cw(2'h2, SIZE_WORD, 2'h2, 8, MODE_MEM_SG));
    entry(32'h010, 32'h930, 32'hA10, cw(INC_NONE, SIZE_WORD, INC_NONE, 1, MODE_AUTO));
    // byte items onto word-spaced slots
    entry(32'h800, 32'h901, 32'hA04, cw(2'h2, 2'h0, 2'h0, 2, MODE_ALT_MEM_SG));
    entry(32'h810, 32'h920, SW_TRIG_ADDR_DEF, cw(INC_NONE, SIZE_WORD, INC_NONE, 1, MODE_BASIC));
    entry(32'h900, 32'h0000_B2A1, 32'h0, 32'h0);
    entry(32'h920, 32'h2, 32'h0, 32'h0);
    entry(32'h930, 32'hC0DE_0001, 32'h0, 32'h0);
    wr(REG_ENASET, 32'h3, RESP_OKAY);
    wr(REG_SWREQ, 32'h1, RESP_OKAY);
    wait_done(1);
    check("byte item 0", m(32'hA00), 32'hA1);
    check("byte item 1", m(32'hA04), 32'hB2);
    check("alt src copy", m(32'h200), 32'h920);
    check("no stray copy", m(32'h1F0), 32'h0);
    check("alt ctl", m(32'h208), cw(INC_NONE, SIZE_WORD, INC_NONE, 1, MODE_STOP));
    check("chained copy", m(32'hA10), 32'hC0DE_0001);
    check("list done", done_cnt[0], 1);
    check("chain done", done_cnt[1], 1);
    rd(REG_ENASET, 32'h0, RESP_OKAY);
  endtask
  task automatic test_per_sg();
    entry(32'h020, 32'hC1C, 32'h22C, cw(2'h2, SIZE_WORD, 2'h2, 8, MODE_PER_SG));
    entry(32'hC00, 32'h940, 32'hB00, cw(INC_NONE, SIZE_WORD, INC_NONE, 1, MODE_ALT_PER_SG));
    entry(32'hC10, 32'h944, 32'hB04, cw(INC_NONE, SIZE_WORD, INC_NONE, 1, MODE_BASIC));
    entry(32'h940, 32'h1111_AAAA, 32'h2222_BBBB, 32'h0);
    wr(REQUEST_MASK_SET_REG, 32'h4, RESP_OKAY);
    rd(REQUEST_MASK_SET_REG, 32'h4, RESP_OKAY);
    wr(REG_ENASET, 32'h4, RESP_OKAY);
    req_burst <= 32'h4;
    repeat (100) @(posedge aclk);
    check("masked", m(32'hB00), 32'h0);
    wr(REQUEST_MASK_CLEAR_REG, 32'h4, RESP_OKAY);
    for (int n = 0; n < 500 && m(32'hB00) !== 32'h1111_AAAA; n++) @(posedge aclk);
    req_burst <= 32'h0;
    check("entry a", m(32'hB00), 32'h1111_AAAA);
    check("per alt copy", m(32'h220), 32'h940);
    repeat (200) @(posedge aclk);
    check("entry b waits", m(32'hB04), 32'h0);
    check("no early done", done_cnt[2], 0);
    req_burst <= 32'h4;
    wait_done(2);
    req_burst <= 32'h0;
    check("entry b", m(32'hB04), 32'h2222_BBBB);
    check("periph done", done_cnt[2], 1);
  endtask
  initial begin
    for (int i = 0; i < 1024; i++) i_mem.mem[i] = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_mem_sg();
    lat <= 4'h3;
    test_per_sg();
    close_out();
  end
endmodule
`default_nettype wire

// file: dv/dsg_mem_model.sv
// dsg_mem_model: single-beat memory behind the engine's memory port.
// assumes byte addresses below 4 KiB; items right-aligned on the data lines.
`default_nettype none
module dsg_mem_model (
  // control
  input wire logic aclk,
  input wire logic [3:0] lat,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [3:0] cnt = 4'h0;
  logic [4:0] sh;
  assign sh = {mem_addr[1:0], 3'h0};
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // ---------------------------------------------------------------
  // access timing
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    // idle lines toggle so stale data never looks valid
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && cnt < lat) begin
      cnt <= cnt + 4'h1;
    end else if (mem_req && !mem_ack) begin
      cnt <= 4'h0;
      mem_ack <= 1'b1;
      if (!mem_we) mem_rdata <= mem[mem_addr[11:2]] >> sh;
      else if (mem_size == 2'h0) mem[mem_addr[11:2]][sh +: 8] <= mem_wdata[7:0];
      else if (mem_size == 2'h1) mem[mem_addr[11:2]][sh +: 16] <= mem_wdata[15:0];
      else mem[mem_addr[11:2]] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// file: hdl/dsg_engine.sv
// dsg_engine: channel sequencer of a multi-channel scatter-gather dma engine.
// assumes an axi4-lite master and a single-beat memory port answering by mem_ack.
`default_nettype none

module dsg_engine
  import dsg_pkg::*;
#(
  parameter int CH = CH_NUM,
  parameter logic [31:0] SW_TRIG_ADDR = SW_TRIG_ADDR_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clken,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // peripheral requests
  input wire logic [CH-1:0] req_single,
  input wire logic [CH-1:0] req_burst,
  // memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // completion
  output logic [CH-1:0] chan_done
);
  localparam int CW = $clog2(CH);
  localparam logic [CH-1:0] ONE = CH'(1);
  localparam logic [XFER_W:0] BLK_ONE = (XFER_W+1)'(1);
  localparam logic [31:0] ALT_BYTES = 32'(CH) << STRUCT_SHIFT;

  typedef enum logic [2:0] {S_IDLE, S_RD_SRC, S_RD_DST, S_RD_CTL, S_ITEM_RD, S_ITEM_WR, S_WB} dsg_state_t;

  dsg_state_t st;
  logic aw_held, w_held, wr_fire, master_en, rd_alt, burst_l, fin, any;
  logic [7:0] aw_addr;
  logic [31:0] w_data, ctl_base, src_end, dst_end, ctl, data, rd_mux;
  logic [CH-1:0] ena, mask, burst_only, alt, swreq, sticky, elig;
  logic [CW-1:0] cur, gnt;
  logic [XFER_W:0] blk, blk_new, items_rem, arb_n;
  logic [31:0] sbase, acc_addr, acc_wdata, src_item, dst_item, ctl_wb;
  logic acc_we;
  logic [XFER_W-1:0] dst_rem;
  logic [1:0] acc_size;
  logic [MODE_W-1:0] mode, r_mode;
  logic wb_ack, ctl_ack, prim_sg, alt_sg, done_ev, stop_ev;
  logic [CH-1:0] cur_oh, stop_vec, done_vec, alt_set_vec, alt_clr_vec;
  logic [CH-1:0] sticky_set_vec, sticky_clr_vec, grant_vec, trig_vec;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  // readies drop with clken so no handshake is lost while frozen
  assign s_awready = clken & ~aw_held;
  assign s_wready = clken & ~w_held;
  assign s_arready = clken & ~s_rvalid;
  assign wr_fire = aw_held & w_held & ~s_bvalid;

  function automatic logic hit(input logic [7:0] a);
    return wr_fire && (aw_addr == a);
  endfunction

  function automatic logic [CH-1:0] wv(input logic [7:0] a);
    return hit(a) ? w_data[CH-1:0] : '0;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= REG_RST;
    end else if (clken) begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata & {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (clken) begin
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= (aw_addr <= REG_STATUS && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = REG_RST;
    case (s_araddr)
      REG_CFG: rd_mux = {31'h0, master_en};
      REG_CTLBASE: rd_mux = ctl_base;
      REG_ENASET: rd_mux = 32'(ena);
      REQUEST_MASK_SET_REG: rd_mux = 32'(mask);
      REG_SWREQ: rd_mux = 32'(swreq);
      REG_BURSTONLY_SET: rd_mux = 32'(burst_only);
      REG_ALTSET: rd_mux = 32'(alt);
      REG_STATUS: rd_mux = (32'(cur) << 8) | {28'h0, 1'b0, 3'(st)};
      default: rd_mux = REG_RST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= REG_RST;
      s_rresp <= RESP_OKAY;
    end else if (clken) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= (s_araddr <= REG_STATUS && s_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel registers; a hardware or software set wins over a clear
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_en <= 1'b0;
      ctl_base <= REG_RST;
    end else if (clken) begin
      if (hit(REG_CFG))
        master_en <= w_data[0];
      if (hit(REG_CTLBASE))
        ctl_base <= {w_data[31:TABLE_ALIGN_BITS], {TABLE_ALIGN_BITS{1'b0}}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ena <= '0;
      mask <= '0;
      burst_only <= '0;
      alt <= '0;
      swreq <= '0;
      sticky <= '0;
      chan_done <= '0;
    end else if (clken) begin
      ena <= (ena & ~wv(REG_ENACLR) & ~stop_vec) | wv(REG_ENASET);
      mask <= (mask & ~wv(REQUEST_MASK_CLEAR_REG)) | wv(REQUEST_MASK_SET_REG);
      burst_only <= (burst_only & ~wv(REG_BURSTONLY_CLR)) | wv(REG_BURSTONLY_SET);
      alt <= (alt & ~wv(REG_ALTCLR) & ~alt_clr_vec) | wv(REG_ALTSET) | alt_set_vec;
      swreq <= (swreq & ~grant_vec) | wv(REG_SWREQ) | trig_vec;
      sticky <= (sticky & ~sticky_clr_vec) | sticky_set_vec;
      chan_done <= done_vec;
    end
  end

  // ---------------------------------------------------------------
  // request gating and fixed-priority grant
  // ---------------------------------------------------------------
  for (genvar i = 0; i < CH; i++) begin : g_ch
    assign elig[i] = master_en & ena[i] & (sticky[i] | swreq[i]
                     | (~mask[i] & (req_burst[i] | (req_single[i] & ~burst_only[i]))));
  end

  always_comb begin
    gnt = '0;
    any = |elig;
    for (int i = CH - 1; i >= 0; i--) begin
      if (elig[i])
        gnt = CW'(i);
    end
  end

  // ---------------------------------------------------------------
  // sequencer events
  // ---------------------------------------------------------------
  assign cur_oh = ONE << cur;
  assign mode = ctl[MODE_W-1:0];
  assign r_mode = mem_rdata[MODE_W-1:0];
  assign wb_ack = (st == S_WB) && mem_req && mem_ack;
  assign ctl_ack = (st == S_RD_CTL) && mem_req && mem_ack;
  assign prim_sg = !rd_alt && (mode == MODE_MEM_SG || mode == MODE_PER_SG);
  assign alt_sg = rd_alt && (mode == MODE_ALT_MEM_SG || mode == MODE_ALT_PER_SG);
  // a non scatter-gather entry ends the list
  assign done_ev = wb_ack && fin && !prim_sg && !alt_sg;
  assign stop_ev = done_ev || (ctl_ack && r_mode == MODE_STOP);

  always_comb begin
    stop_vec = stop_ev ? cur_oh : '0;
    done_vec = done_ev ? cur_oh : '0;
    // every entry copy is followed by running the alternate
    alt_set_vec = (wb_ack && prim_sg) ? cur_oh : '0;
    alt_clr_vec = (wb_ack && fin && alt_sg) ? cur_oh : '0;
    sticky_set_vec = (ctl_ack && r_mode inside {MODE_AUTO, MODE_MEM_SG, MODE_ALT_MEM_SG, MODE_PER_SG})
                     ? cur_oh : '0;
    // peripheral list waits for a fresh request per entry
    sticky_clr_vec = (stop_ev || (wb_ack && fin && rd_alt && mode == MODE_ALT_PER_SG)) ? cur_oh : '0;
    grant_vec = (st == S_IDLE && any) ? (ONE << gnt) : '0;
    trig_vec = (st == S_ITEM_WR && mem_req && mem_ack && mem_addr == SW_TRIG_ADDR)
               ? mem_wdata[CH-1:0] : '0;
  end

  // block length: burst, auto and lists run a full arbitration block
  always_comb begin
    items_rem = (XFER_W+1)'(mem_rdata[F_XFER+:XFER_W]) + BLK_ONE;
    arb_n = BLK_ONE << mem_rdata[F_ARB+:ARB_W];
    if (mem_rdata[F_ARB+:ARB_W] >= ARB_ALL || arb_n > items_rem)
      arb_n = items_rem;
    blk_new = (burst_l || sticky[cur] || !(r_mode inside {MODE_BASIC, MODE_ALT_PER_SG}))
              ? arb_n : BLK_ONE;
  end

  // ---------------------------------------------------------------
  // memory accesses
  // ---------------------------------------------------------------
  dsg_item_addr u_src (
    .end_ptr(src_end),
    .remain(ctl[F_XFER+:XFER_W]),
    .inc(ctl[F_SRCINC+:2]),
    .addr(src_item)
  );

  // a list copy lands every entry on the same four alternate words
  // limitation: the primary block must be four items, one entry per block
  assign dst_rem = prim_sg ? XFER_W'(ctl[F_XFER+:2]) : ctl[F_XFER+:XFER_W];

  dsg_item_addr u_dst (
    .end_ptr(dst_end),
    .remain(dst_rem),
    .inc(ctl[F_DSTINC+:2]),
    .addr(dst_item)
  );

  always_comb begin
    sbase = ctl_base + (rd_alt ? ALT_BYTES : REG_RST) + (32'(cur) << STRUCT_SHIFT);
    ctl_wb = fin ? {ctl[31:MODE_W], MODE_STOP} : ctl;
    acc_addr = sbase + OFS_SRC_END;
    acc_we = 1'b0;
    acc_size = SIZE_WORD;
    acc_wdata = ctl_wb;
    unique case (st)
      S_RD_DST: acc_addr = sbase + OFS_DST_END;
      S_RD_CTL: acc_addr = sbase + OFS_CTL;
      S_ITEM_RD: begin
        acc_addr = src_item;
        acc_size = ctl[F_SRCSIZE+:2];
      end
      S_ITEM_WR: begin
        acc_addr = dst_item;
        acc_we = 1'b1;
        acc_size = ctl[F_DSTSIZE+:2];
        acc_wdata = data;
      end
      S_WB: begin
        acc_addr = sbase + OFS_CTL;
        acc_we = 1'b1;
      end
      default: acc_we = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= S_IDLE;
      cur <= '0;
      rd_alt <= 1'b0;
      burst_l <= 1'b0;
      fin <= 1'b0;
      blk <= '0;
      src_end <= REG_RST;
      dst_end <= REG_RST;
      ctl <= REG_RST;
      data <= REG_RST;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= REG_RST;
      mem_size <= SIZE_WORD;
      mem_wdata <= REG_RST;
    end else if (clken) begin
      if (st == S_IDLE) begin
        if (any) begin
          cur <= gnt;
          rd_alt <= alt[gnt];
          burst_l <= req_burst[gnt] & ~mask[gnt];
          st <= S_RD_SRC;
        end
      end else if (!mem_req) begin
        mem_req <= 1'b1;
        mem_we <= acc_we;
        mem_addr <= acc_addr;
        mem_size <= acc_size;
        mem_wdata <= acc_wdata;
      end else if (mem_ack) begin
        mem_req <= 1'b0;
        unique case (st)
          S_RD_SRC: begin
            src_end <= mem_rdata;
            st <= S_RD_DST;
          end
          S_RD_DST: begin
            dst_end <= mem_rdata;
            st <= S_RD_CTL;
          end
          S_RD_CTL: begin
            ctl <= mem_rdata;
            fin <= 1'b0;
            blk <= blk_new;
            st <= (r_mode == MODE_STOP) ? S_IDLE : S_ITEM_RD;
          end
          S_ITEM_RD: begin
            data <= mem_rdata;
            st <= S_ITEM_WR;
          end
          S_ITEM_WR: begin
            if (ctl[F_XFER+:XFER_W] == '0) begin
              fin <= 1'b1;
              st <= S_WB;
            end else begin
              ctl[F_XFER+:XFER_W] <= ctl[F_XFER+:XFER_W] - XFER_W'(1);
              blk <= blk - BLK_ONE;
              st <= (blk == BLK_ONE) ? S_WB : S_ITEM_RD;
            end
          end
          S_WB: st <= S_IDLE;
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wb_ack;
    clken && wb_ack;
  endsequence

  sequence s_start;
    st == S_RD_SRC && $past(st) == S_IDLE && $past(clken);
  endsequence

  a_start_enabled: assert property (s_start |-> ena[cur] && master_en)
    else $error("block started on a disabled channel");
  a_start_unmasked: assert property (s_start |-> $past(sticky[gnt] || swreq[gnt] ||
    (!mask[gnt] && (req_burst[gnt] || req_single[gnt]))))
    else $error("masked request started a block");
  a_mask_set: assert property (clken && hit(REQUEST_MASK_SET_REG) |=>
    (mask & $past(w_data[CH-1:0])) == $past(w_data[CH-1:0]))
    else $error("mask set write not applied");
  a_copy_to_alt: assert property (s_wb_ack ##0 prim_sg |=> alt[cur] && st == S_IDLE)
    else $error("entry copy did not select alternate");
  a_final_stops: assert property (|chan_done |-> chan_done == cur_oh && (ena & chan_done) == '0)
    else $error("final entry left channel enabled");
  a_no_mid_done: assert property (s_wb_ack ##0 (prim_sg || alt_sg) |=> chan_done == '0)
    else $error("completion after intermediate entry");
  a_stop_written: assert property (st == S_WB && mem_req && fin |-> mem_wdata[MODE_W-1:0] == MODE_STOP)
    else $error("stop mode not written back");
  a_fixed_addr: assert property (st == S_ITEM_RD && mem_req && ctl[F_SRCINC+:2] == INC_NONE
    |-> mem_addr == src_end)
    else $error("fixed source address moved");
  a_block_runs: assert property (clken && st == S_ITEM_WR && mem_req && mem_ack && blk > BLK_ONE
    && ctl[F_XFER+:XFER_W] != '0 |=> st == S_ITEM_RD && $stable(cur))
    else $error("block broken before its end");
  a_sw_trigger: assert property (clken && st == S_ITEM_WR && mem_req && mem_ack
    && mem_addr == SW_TRIG_ADDR |=> (swreq & $past(mem_wdata[CH-1:0])) == $past(mem_wdata[CH-1:0]))
    else $error("trigger write did not request channel");
  a_mem_list_runs: assert property (clken && ctl_ack && r_mode == MODE_MEM_SG |=> sticky[cur])
    else $error("memory list not held running");
endmodule

`default_nettype wire

// file: hdl/dsg_item_addr.sv
// dsg_item_addr: address of the current item from an inclusive end pointer.
// assumes remain holds items left minus one, as the control word does.
`default_nettype none

module dsg_item_addr
  import dsg_pkg::*;
(
  // pointer and count
  input wire logic [31:0] end_ptr,
  input wire logic [XFER_W-1:0] remain,
  input wire logic [1:0] inc,
  // result
  output logic [31:0] addr
);
  logic [31:0] ofs;

  always_comb begin
    ofs = 32'(remain) << inc;
    // a fixed side always uses the pointer itself
    addr = (inc == INC_NONE) ? end_ptr : end_ptr - ofs;
  end
endmodule

`default_nettype wire

// file: hdl/dsg_pkg.sv
// dsg_pkg: constants shared by the dma scatter-gather engine.
// assumes 32-bit words and a control table aligned to its own size.
`default_nettype none

package dsg_pkg;
  // ---------------------------------------------------------------
  // control table geometry
  // ---------------------------------------------------------------
  localparam int CH_NUM = 32;
  localparam int STRUCT_SHIFT = 4;
  localparam int TABLE_ALIGN_BITS = 10;
  localparam logic [31:0] OFS_SRC_END = 32'h0000_0000;
  localparam logic [31:0] OFS_DST_END = 32'h0000_0004;
  localparam logic [31:0] OFS_CTL = 32'h0000_0008;

  // ---------------------------------------------------------------
  // control word fields
  // ---------------------------------------------------------------
  localparam int F_DSTINC = 30;
  localparam int F_DSTSIZE = 28;
  localparam int F_SRCINC = 26;
  localparam int F_SRCSIZE = 24;
  localparam int F_ARB = 14;
  localparam int F_XFER = 4;
  localparam int XFER_W = 10;
  localparam int ARB_W = 4;
  localparam int MODE_W = 3;
  localparam logic [1:0] INC_NONE = 2'h3;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // 2^10 items already cover the largest transfer count
  localparam logic [ARB_W-1:0] ARB_ALL = 4'hA;

  // transfer modes
  localparam logic [MODE_W-1:0] MODE_STOP = 3'h0;
  localparam logic [MODE_W-1:0] MODE_BASIC = 3'h1;
  localparam logic [MODE_W-1:0] MODE_AUTO = 3'h2;
  localparam logic [MODE_W-1:0] MODE_MEM_SG = 3'h4;
  localparam logic [MODE_W-1:0] MODE_ALT_MEM_SG = 3'h5;
  localparam logic [MODE_W-1:0] MODE_PER_SG = 3'h6;
  localparam logic [MODE_W-1:0] MODE_ALT_PER_SG = 3'h7;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CTLBASE = 8'h04;
  localparam logic [7:0] REG_ENASET = 8'h08;
  localparam logic [7:0] REG_ENACLR = 8'h0C;
  localparam logic [7:0] REQUEST_MASK_SET_REG = 8'h10;
  localparam logic [7:0] REQUEST_MASK_CLEAR_REG = 8'h14;
  localparam logic [7:0] REG_SWREQ = 8'h18;
  localparam logic [7:0] REG_BURSTONLY_SET = 8'h1C;
  localparam logic [7:0] REG_BURSTONLY_CLR = 8'h20;
  localparam logic [7:0] REG_ALTSET = 8'h24;
  localparam logic [7:0] REG_ALTCLR = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2C;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // arbitrary default
  localparam logic [31:0] SW_TRIG_ADDR_DEF = 32'h0000_0F00;
endpackage

`default_nettype wire
